// File: rtl/power_pkg.sv
// Constants and types shared by the power and clock control block
package power_pkg;

  // ==========================================================
  // Sizes
  localparam int PERIPH_N = 16;
  localparam int EXT_PINS = 9;
  localparam int EXT_REQS = 4;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_MODE       = 8'h00;
  localparam logic [7:0] OFF_PERIPH_PWR = 8'h04;
  localparam logic [7:0] OFF_CLK_DIV    = 8'h08;
  localparam logic [7:0] OFF_RTC_SRC    = 8'h0c;
  localparam logic [7:0] OFF_EXT_ENABLE = 8'h10;
  localparam logic [7:0] OFF_EXT_EDGE   = 8'h14;
  localparam logic [7:0] OFF_EXT_POL    = 8'h18;
  localparam logic [7:0] OFF_EXT_WAKE   = 8'h1c;
  localparam logic [7:0] OFF_EXT_FLAG   = 8'h20;
  localparam logic [7:0] OFF_STATUS     = 8'h24;

  // ==========================================================
  // Field positions
  localparam int MODE_IDLE_BIT  = 0;
  localparam int MODE_PDOWN_BIT = 1;

  // ==========================================================
  // Reset values
  localparam logic [15:0] PWR_RESET = 16'hffff;
  localparam logic [1:0]  DIV_RESET = 2'h0;
  localparam logic [8:0]  EXT_RESET = 9'h000;

  // ==========================================================
  // Divider select encodings
  localparam logic [1:0] DIV_QUARTER = 2'h0;
  localparam logic [1:0] DIV_FULL    = 2'h1;
  localparam logic [1:0] DIV_HALF    = 2'h2;

  // ==========================================================
  // Timing and bus answers
  localparam logic [7:0] WAKE_CYCLES = 8'h10;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Wake causes and power states
  localparam logic [1:0] CAUSE_NONE  = 2'h0;
  localparam logic [1:0] CAUSE_IRQ   = 2'h1;
  localparam logic [1:0] CAUSE_PIN   = 2'h2;
  localparam logic [1:0] CAUSE_OTHER = 2'h3;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_IDLE,
    ST_PDOWN,
    ST_WAKE
  } pm_state_t;

endpackage : power_pkg

// File: rtl/periph_clk_divider.sv
// Peripheral clock enable divider with boundary-aligned ratio change
`timescale 1ns/1ns
module periph_clk_divider
  import power_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Control
  input  wire logic [1:0] div_sel,
  input  wire logic       run,
  // Peripheral clock tick
  output logic            tick
);

  typedef struct packed {
    logic [1:0] cnt;
    logic [1:0] ratio;
    logic       tick;
  } div_state_t;

  div_state_t q;
  div_state_t d;

  // Last count value of a period for a select code
  function automatic logic [1:0] ratio_of(input logic [1:0] sel);
    case (sel)
      DIV_FULL: ratio_of = 2'h0;
      DIV_HALF: ratio_of = 2'h1;
      default:  ratio_of = 2'h3;
    endcase
  endfunction : ratio_of

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (!run) begin
      d.cnt = 2'h0;
      d.ratio = ratio_of(div_sel);
    end else if (q.cnt == q.ratio) begin
      d.cnt = 2'h0;
      d.tick = 1'b1;
      d.ratio = ratio_of(div_sel);
    end else begin
      d.cnt = q.cnt + 2'h1;
    end
    if (!rst_b) begin
      d = '0;
      d.ratio = ratio_of(DIV_RESET);
    end
  end

  always_ff @(posedge sys_clk) begin
    q <= d;
  end

  assign tick = q.tick;

endmodule : periph_clk_divider

// File: rtl/ext_int_unit.sv
// External interrupt pins folded into four request flags
`timescale 1ns/1ns
module ext_int_unit
  import power_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  // Pins and configuration
  input  wire logic [EXT_PINS-1:0] pin,
  input  wire logic [EXT_PINS-1:0] pin_enable,
  input  wire logic [EXT_PINS-1:0] edge_mode,
  input  wire logic [EXT_PINS-1:0] high_active,
  // Flag clear and requests
  input  wire logic [EXT_REQS-1:0] flag_clear,
  output logic      [EXT_REQS-1:0] irq_req
);

  typedef struct packed {
    logic [EXT_PINS-1:0] prev;
    logic [EXT_REQS-1:0] flag;
  } ext_state_t;

  ext_state_t q;
  ext_state_t d;

  always_comb begin
    logic [EXT_REQS-1:0] set;
    logic [EXT_PINS-1:0] lvl;
    logic [EXT_PINS-1:0] old;
    set = '0;
    lvl = ~(pin ^ high_active);
    old = ~(q.prev ^ high_active);
    for (int i = 0; i < EXT_PINS; i++) begin
      if (pin_enable[i] && (edge_mode[i] ? (lvl[i] && !old[i]) : lvl[i])) begin
        set[i % EXT_REQS] = 1'b1;
      end
    end
    d.prev = pin;
    d.flag = (q.flag & ~flag_clear) | set;
    if (!rst_b) begin
      d = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    q <= d;
  end

  assign irq_req = q.flag;

endmodule : ext_int_unit

// File: rtl/power_mode_clock_control.sv
// Power mode, peripheral clock and power control with AXI4-Lite registers
//
// Overview of operation
// - Idle halts execution until reset or interrupt
// - Peripheral clocks keep running during Idle
// - Power-down stops oscillator and all clocks
// - Power-down keeps state and freezes output pins
// - Power-down ends on reset or clockless interrupt
// - Each external interrupt can wake Power-down
// - Nine external pins feed four interrupt requests
// - External RTC clock keeps RTC counting
// - Every peripheral has its own power switch
// - Peripheral clock divides processor clock by 1/2/4
// - Divider resets to one quarter rate
// - PLL stays active during Idle
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
module power_mode_clock_control
  import power_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  // AXI4-Lite write address
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Processor core
  output logic                     core_run,
  input  wire logic                irq_pending,
  // Clock sources
  output logic                     osc_enable,
  output logic                     pll_allow,
  output logic                     peripheral_bus_tick,
  // Peripherals
  output logic [PERIPH_N-1:0]      periph_power_on,
  output logic [PERIPH_N-1:0]      periph_clk_en,
  // Real-time clock
  output logic                     rtc_ext_clk_sel,
  output logic                     rtc_run,
  // Pins
  output logic                     pin_hold,
  input  wire logic [EXT_PINS-1:0] ext_int_pin,
  output logic [EXT_REQS-1:0]      ext_irq,
  input  wire logic                clockless_wake
);

  // ==========================================================
  // State
  typedef struct packed {
    pm_state_t           state;
    logic [7:0]          wake_cnt;
    logic [1:0]          wake_cause;
    logic                idle_req;
    logic                pd_req;
    logic [PERIPH_N-1:0] periph_pwr;
    logic [1:0]          div_sel;
    logic                rtc_ext;
    logic [EXT_PINS-1:0] ext_en;
    logic [EXT_PINS-1:0] ext_edge;
    logic [EXT_PINS-1:0] ext_pol;
    logic [EXT_REQS-1:0] ext_wake;
    logic [EXT_REQS-1:0] flag_clear;
    logic                awready;
    logic                wready;
    logic                aw_held;
    logic                w_held;
    logic [7:0]          awaddr;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic                core_run;
    logic                osc_en;
    logic                pll_allow;
    logic                periph_run;
    logic [PERIPH_N-1:0] clk_en;
    logic                rtc_run;
    logic                pin_hold;
  } top_state_t;

  top_state_t q;
  top_state_t d;

  logic [EXT_REQS-1:0] ext_req;
  logic                bus_tick;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = strb[b] ? nv[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : merge

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= OFF_STATUS);
  endfunction : addr_ok

  // ==========================================================
  // Submodules
  // Divider restarts its period whenever the run enable returns
  periph_clk_divider u_div (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .div_sel (q.div_sel),
    .run     (q.periph_run),
    .tick    (bus_tick)
  );

  // Pin i feeds request i mod 4
  ext_int_unit u_ext (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .pin         (ext_int_pin),
    .pin_enable  (q.ext_en),
    .edge_mode   (q.ext_edge),
    .high_active (q.ext_pol),
    .flag_clear  (q.flag_clear),
    .irq_req     (ext_req)
  );

  // ==========================================================
  // Next state
  always_comb begin
    logic [31:0] rd;
    logic [31:0] nv;
    logic        pd_wake;
    rd = '0;
    nv = '0;
    pd_wake = 1'b0;
    d = q;
    d.flag_clear = '0;

    // Write channel
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (s_axi_awvalid && q.awready) begin
      d.aw_held = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_held = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.aw_held && q.w_held && !q.bvalid) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = addr_ok(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      // Word lands only once address and data are both held
      case (q.awaddr)
        OFF_MODE: begin
          nv = merge({30'h0, q.pd_req, q.idle_req}, q.wdata, q.wstrb);
          d.idle_req = nv[MODE_IDLE_BIT];
          d.pd_req = nv[MODE_PDOWN_BIT];
        end
        OFF_PERIPH_PWR: begin
          nv = merge({16'h0, q.periph_pwr}, q.wdata, q.wstrb);
          d.periph_pwr = nv[PERIPH_N-1:0];
        end
        OFF_CLK_DIV: begin
          nv = merge({30'h0, q.div_sel}, q.wdata, q.wstrb);
          d.div_sel = nv[1:0];
        end
        OFF_RTC_SRC: begin
          nv = merge({31'h0, q.rtc_ext}, q.wdata, q.wstrb);
          d.rtc_ext = nv[0];
        end
        OFF_EXT_ENABLE: begin
          nv = merge({23'h0, q.ext_en}, q.wdata, q.wstrb);
          d.ext_en = nv[EXT_PINS-1:0];
        end
        OFF_EXT_EDGE: begin
          nv = merge({23'h0, q.ext_edge}, q.wdata, q.wstrb);
          d.ext_edge = nv[EXT_PINS-1:0];
        end
        OFF_EXT_POL: begin
          nv = merge({23'h0, q.ext_pol}, q.wdata, q.wstrb);
          d.ext_pol = nv[EXT_PINS-1:0];
        end
        OFF_EXT_WAKE: begin
          nv = merge({28'h0, q.ext_wake}, q.wdata, q.wstrb);
          d.ext_wake = nv[EXT_REQS-1:0];
        end
        OFF_EXT_FLAG: begin
          if (q.wstrb[0]) begin
            d.flag_clear = q.wdata[EXT_REQS-1:0];
          end
        end
        default: begin
          d.bresp = addr_ok(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
        end
      endcase
    end
    // Ready stays low while a held word waits for its response
    d.awready = !d.aw_held;
    d.wready = !d.w_held;

    // Read channel
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      case (s_axi_araddr)
        OFF_MODE:       rd = {30'h0, q.pd_req, q.idle_req};
        OFF_PERIPH_PWR: rd = {16'h0, q.periph_pwr};
        OFF_CLK_DIV:    rd = {30'h0, q.div_sel};
        OFF_RTC_SRC:    rd = {31'h0, q.rtc_ext};
        OFF_EXT_ENABLE: rd = {23'h0, q.ext_en};
        OFF_EXT_EDGE:   rd = {23'h0, q.ext_edge};
        OFF_EXT_POL:    rd = {23'h0, q.ext_pol};
        OFF_EXT_WAKE:   rd = {28'h0, q.ext_wake};
        OFF_EXT_FLAG:   rd = {28'h0, ext_req};
        OFF_STATUS:     rd = {22'h0, q.div_sel, ext_req, q.wake_cause, q.state};
        default:        rd = '0;
      endcase
      d.rdata = rd;
      d.rresp = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      d.rvalid = 1'b1;
    end
    // One read at a time: next address waits for the data
    d.arready = !d.rvalid;

    // Power mode sequencing
    // Only enabled pin requests or the clockless source end power-down
    pd_wake = (|(ext_req & q.ext_wake)) || clockless_wake;
    case (q.state)
      ST_RUN: begin
        if (q.pd_req) begin
          d.state = ST_PDOWN;
        end else if (q.idle_req) begin
          d.state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (irq_pending || (|ext_req)) begin
          d.state = ST_RUN;
          d.idle_req = 1'b0;
          d.pd_req = 1'b0;
          d.wake_cause = CAUSE_IRQ;
        end
      end
      ST_PDOWN: begin
        if (pd_wake) begin
          d.state = ST_WAKE;
          d.wake_cnt = WAKE_CYCLES;
          d.idle_req = 1'b0;
          d.pd_req = 1'b0;
          d.wake_cause = clockless_wake ? CAUSE_OTHER : CAUSE_PIN;
        end
      end
      ST_WAKE: begin
        // Oscillator start-up wait before the core may run
        if (q.wake_cnt <= 8'h01) begin
          d.state = ST_RUN;
          d.wake_cnt = 8'h00;
        end else begin
          d.wake_cnt = q.wake_cnt - 8'h01;
        end
      end
      default: begin
        d.state = ST_RUN;
      end
    endcase

    // Registered outputs follow the next state
    d.core_run = (d.state == ST_RUN);
    d.periph_run = (d.state == ST_RUN) || (d.state == ST_IDLE);
    // Gated clocks follow the power switches
    d.clk_en = d.periph_run ? d.periph_pwr : '0;
    d.osc_en = (d.state != ST_PDOWN);
    d.pll_allow = (d.state != ST_PDOWN);
    // Pins stay frozen until the core runs again
    d.pin_hold = (d.state == ST_PDOWN) || (d.state == ST_WAKE);
    d.rtc_run = d.periph_run || d.rtc_ext;

    // Synchronous reset
    // Reset overrides every update above
    if (!rst_b) begin
      d = '0;
      d.state = ST_RUN;
      d.wake_cause = CAUSE_NONE;
      d.periph_pwr = PWR_RESET;
      d.div_sel = DIV_RESET;
      d.ext_en = EXT_RESET;
      d.ext_edge = EXT_RESET;
      d.ext_pol = EXT_RESET;
      d.osc_en = 1'b1;
      d.pll_allow = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    q <= d;
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready       = q.awready;
  assign s_axi_wready        = q.wready;
  assign s_axi_bresp         = q.bresp;
  assign s_axi_bvalid        = q.bvalid;
  assign s_axi_arready       = q.arready;
  assign s_axi_rdata         = q.rdata;
  assign s_axi_rresp         = q.rresp;
  assign s_axi_rvalid        = q.rvalid;
  assign core_run            = q.core_run;
  assign osc_enable          = q.osc_en;
  assign pll_allow           = q.pll_allow;
  assign peripheral_bus_tick = bus_tick;
  assign periph_power_on     = q.periph_pwr;
  assign periph_clk_en       = q.clk_en;
  assign rtc_ext_clk_sel     = q.rtc_ext;
  assign rtc_run             = q.rtc_run;
  assign pin_hold            = q.pin_hold;
  assign ext_irq             = ext_req;

endmodule : power_mode_clock_control

// File: sim/power_mode_clock_control_props.sv
// Checker for the power mode and clock control block
`timescale 1ns/1ns
module power_mode_clock_control_props
  import power_pkg::*;
(
  input wire logic                sys_clk,
  input wire logic                rst_b,
  input wire logic                s_axi_bvalid,
  input wire logic                core_run,
  input wire logic                irq_pending,
  input wire logic                osc_enable,
  input wire logic                pll_allow,
  input wire logic                peripheral_bus_tick,
  input wire logic [PERIPH_N-1:0] periph_power_on,
  input wire logic [PERIPH_N-1:0] periph_clk_en,
  input wire logic                rtc_ext_clk_sel,
  input wire logic                rtc_run,
  input wire logic                pin_hold,
  input wire logic [EXT_REQS-1:0] ext_irq,
  input wire logic                clockless_wake
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ==========================================================
  // Sequences
  sequence s_quarter;
    peripheral_bus_tick ##1 !peripheral_bus_tick [*3] ##1 peripheral_bus_tick;
  endsequence
  sequence s_idle;
    !core_run && osc_enable && !pin_hold && $past(rst_b);
  endsequence
  sequence s_back_to_run;
    ##[1:24] (core_run && !pin_hold);
  endsequence

  // ==========================================================
  // Assertions
  AST_DIV_RESET: assert property ($rose(rst_b) |-> ##[1:6] s_quarter)
    else $error("peripheral tick not at quarter rate after reset");
  AST_IDLE_CLOCKS: assert property ($fell(core_run) && osc_enable |-> pll_allow && periph_clk_en == periph_power_on)
    else $error("clocks stopped on idle entry");
  AST_IDLE_HOLD: assert property (s_idle and !irq_pending && ext_irq == 4'h0 |=> !core_run)
    else $error("idle left without interrupt");
  AST_IDLE_WAKE: assert property (s_idle and irq_pending |-> ##[1:2] core_run)
    else $error("idle not left on interrupt");
  AST_PDOWN_OFF: assert property (!osc_enable |-> !pll_allow && !core_run && periph_clk_en == 16'h0000)
    else $error("clock still on in power-down");
  AST_PDOWN_TICK: assert property (!osc_enable && !$past(osc_enable) |-> !peripheral_bus_tick)
    else $error("peripheral tick in power-down");
  AST_PDOWN_KEEP: assert property (!osc_enable |-> pin_hold && $stable(periph_power_on))
    else $error("state or pins not held in power-down");
  AST_PDOWN_WAKE: assert property (!osc_enable && clockless_wake |-> ##[1:2] osc_enable ##0 s_back_to_run)
    else $error("power-down not left on clockless wake");
  AST_RTC_EXT: assert property (rtc_ext_clk_sel && $past(rtc_ext_clk_sel) |-> rtc_run)
    else $error("external rtc clock stopped");
  AST_RTC_OFF: assert property (!osc_enable && !$past(osc_enable) && !rtc_ext_clk_sel |-> !rtc_run)
    else $error("rtc runs from stopped clock");
  AST_FLAG_STICKY: assert property (($past(ext_irq) & ~ext_irq) != 4'h0 |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("request flag dropped without clear");
endmodule : power_mode_clock_control_props

bind power_mode_clock_control power_mode_clock_control_props props_u (.*);

// File: sim/core_periph_model.sv
// Processor core and peripheral side model
`timescale 1ns/1ns
module core_periph_model
  import power_pkg::*;
(
  // Clock
  input  wire logic                sys_clk,
  // From the block
  input  wire logic                core_run,
  input  wire logic                peripheral_bus_tick,
  input  wire logic [PERIPH_N-1:0] periph_clk_en,
  // Bench commands
  input  wire logic                arm_timer,
  input  wire logic [EXT_PINS-1:0] pin_cmd,
  input  wire logic                wake_cmd,
  // Towards the block
  output logic                     irq_pending,
  output logic [EXT_PINS-1:0]      ext_int_pin,
  output logic                     clockless_wake
);
  logic [3:0] ticks_q;
  logic       step;

  initial begin
    irq_pending = 1'b0;
    ticks_q = 4'h0;
  end

  // Peripheral timer counts only clocked ticks
  assign step = peripheral_bus_tick && periph_clk_en[0];

  always @(posedge sys_clk) begin
    ext_int_pin <= pin_cmd;
    clockless_wake <= wake_cmd;
    if (arm_timer) ticks_q <= 4'h6;
    else if (step && ticks_q != 4'h0) ticks_q <= ticks_q - 4'h1;
    // Request held until the core runs again
    irq_pending <= (step && ticks_q == 4'h1) || (irq_pending && !core_run);
  end
endmodule : core_periph_model

// File: sim/power_mode_clock_control_bench.sv
// Self-checking bench for the power mode and clock control block
`timescale 1ns/1ns
module power_mode_clock_control_bench
  import power_pkg::*;
;
  logic sys_clk = 1'b0, rst_b = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic core_run, irq_pending, osc_enable, pll_allow, peripheral_bus_tick;
  logic rtc_ext_clk_sel, rtc_run, pin_hold, clockless_wake;
  logic [PERIPH_N-1:0] periph_power_on, periph_clk_en;
  logic [EXT_PINS-1:0] ext_int_pin, pin_cmd = 9'h000;
  logic [EXT_REQS-1:0] ext_irq;
  logic arm_timer = 1'b0, wake_cmd = 1'b0;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [33:0] r_exp;
  int n_fail = 0, n_checks = 0;

  power_mode_clock_control dut_u (.*);
  core_periph_model model_u (.*);

  always #50 sys_clk = ~sys_clk;

  // ==========================================================
  // Tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge sys_clk);
      if (!ta && s_axi_awready) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!tw && s_axi_wready) begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (!s_axi_bvalid);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
  endtask : rd

  task automatic ticks(input int cyc, input int exp, input string what);
    int c;
    c = 0;
    repeat (cyc) begin
      @(posedge sys_clk);
      if (peripheral_bus_tick === 1'b1) c++;
    end
    chk(what, exp, c);
  endtask : ticks

  task automatic wait_run;
    for (int i = 0; i < 200 && core_run !== 1'b1; i++) @(posedge sys_clk);
    chk("core_run", 32'h1, {31'h0, core_run});
  endtask : wait_run

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // ==========================================================
  // Response monitor
  always @(posedge sys_clk) begin
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {30'h0, bq.pop_front()}, {30'h0, s_axi_bresp});
    if (s_axi_rvalid && s_axi_rready) begin
      r_exp = rq.pop_front();
      chk("rdata", r_exp[31:0], s_axi_rdata);
      chk("rresp", {30'h0, r_exp[33:32]}, {30'h0, s_axi_rresp});
    end
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    end_of_test;
  end

  // ==========================================================
  // Main sequence
  initial begin
    int p;
    logic [15:0] pw;
    void'($urandom(32'hdb2a));
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rd(OFF_PERIPH_PWR, {16'h0, PWR_RESET}, RESP_OKAY);
    rd(OFF_CLK_DIV, {30'h0, DIV_QUARTER}, RESP_OKAY);
    rd(OFF_STATUS, 32'h0, RESP_OKAY);
    rd(8'h28, 32'h0, RESP_SLVERR);
    wr(8'h02, 32'h1, RESP_SLVERR);
    pw = 16'($urandom) | 16'h0001;
    wr(OFF_PERIPH_PWR, {16'h0, pw}, RESP_OKAY);
    rd(OFF_PERIPH_PWR, {16'h0, pw}, RESP_OKAY);
    chk("clk_en", {16'h0, pw}, {16'h0, periph_clk_en});
    // Ratios full, quarter, quarter alias, half
    for (int k = 0; k < 4; k++) begin
      wr(OFF_CLK_DIV, 32'(k ^ 1), RESP_OKAY);
      repeat (8) @(posedge sys_clk);
      ticks(40, (k == 0) ? 40 : (k == 3) ? 20 : 10, "tick_count");
    end
    // Idle, woken by a peripheral timer
    wr(OFF_MODE, 32'h1, RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    chk("core_run", 32'h0, {31'h0, core_run});
    chk("pll_allow", 32'h1, {31'h0, pll_allow});
    arm_timer <= 1'b1;
    @(posedge sys_clk);
    arm_timer <= 1'b0;
    ticks(8, 4, "idle_ticks");
    wait_run;
    rd(OFF_MODE, 32'h0, RESP_OKAY);
    // External pin, rising edge, wake enabled
    p = $urandom_range(8, 0);
    wr(OFF_EXT_POL, 32'h1 << p, RESP_OKAY);
    wr(OFF_EXT_EDGE, 32'h1 << p, RESP_OKAY);
    wr(OFF_EXT_ENABLE, 32'h1 << p, RESP_OKAY);
    wr(OFF_EXT_WAKE, 32'h1 << (p % 4), RESP_OKAY);
    pin_cmd <= 9'(1 << p);
    repeat (4) @(posedge sys_clk);
    chk("ext_irq", 32'h1 << (p % 4), {28'h0, ext_irq});
    wr(OFF_EXT_FLAG, 32'h1 << (p % 4), RESP_OKAY);
    rd(OFF_EXT_FLAG, 32'h0, RESP_OKAY);
    // Power-down, woken by the pin
    pin_cmd <= 9'h000;
    wr(OFF_MODE, 32'h2, RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    chk("osc_enable", 32'h0, {31'h0, osc_enable});
    chk("pin_hold", 32'h1, {31'h0, pin_hold});
    ticks(8, 0, "pd_ticks");
    pin_cmd <= 9'(1 << p);
    wait_run;
    rd(OFF_PERIPH_PWR, {16'h0, pw}, RESP_OKAY);
    rd(OFF_STATUS, {22'h0, DIV_HALF, 4'(1 << (p % 4)), CAUSE_PIN, 2'h0}, RESP_OKAY);
    // Power-down with external rtc clock, clockless wake
    wr(OFF_EXT_FLAG, 32'h1 << (p % 4), RESP_OKAY);
    wr(OFF_RTC_SRC, 32'h1, RESP_OKAY);
    wr(OFF_MODE, 32'h2, RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    chk("rtc_run", 32'h1, {31'h0, rtc_run});
    wake_cmd <= 1'b1;
    wait_run;
    wake_cmd <= 1'b0;
    rd(OFF_STATUS, {22'h0, DIV_HALF, 4'h0, CAUSE_OTHER, 2'h0}, RESP_OKAY);
    // Level mode, active low: clear loses to a pin still active
    wr(OFF_EXT_POL, 32'h0, RESP_OKAY);
    wr(OFF_EXT_EDGE, 32'h0, RESP_OKAY);
    rd(OFF_EXT_FLAG, 32'h0, RESP_OKAY);
    pin_cmd <= 9'h000;
    wr(OFF_EXT_FLAG, 32'h1 << (p % 4), RESP_OKAY);
    rd(OFF_EXT_FLAG, 32'h1 << (p % 4), RESP_OKAY);
    // Partial write keeps the low byte
    s_axi_wstrb <= 4'h2;
    wr(OFF_PERIPH_PWR, 32'h0, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(OFF_PERIPH_PWR, {16'h0, 8'h00, pw[7:0]}, RESP_OKAY);
    chk("power_on", {16'h0, 8'h00, pw[7:0]}, {16'h0, periph_power_on});
    end_of_test;
  end
endmodule : power_mode_clock_control_bench
